// file: inc/amp_ctrl_consts.vh
// offsets, field positions, reset values and codes for the amplifier control registers
// Summary of operation
// - Writing one to bit 4 of the reset register resets the whole digital path, coefficient memory and all control registers.
// - Writing one to bit 0 of the reset register returns only the control registers to their defaults, coefficient memory kept.
// - Both reset bits are self-clearing write strobes that fire once and read back as zero.
// - Switching frequency field 6-4 decodes 000 384 kHz, 010 480 kHz, 011 576 kHz, 100 768 kHz, others reserved.
// - Bit 2 of the output stage register selects bridge-tied output at zero and parallel bridge output at one.
// - Modulation field 1-0 selects dual-phase at 00, single-sided at 01 and hybrid at 10.
// - The dsp hold bit 4 resets to one and holds the DSP in reset; clearing it lets the DSP power up.
// - Mute bit 3 requests a soft mute of both channels with smooth ramps down and back up.
// - State field 1-0 selects deep sleep 00, sleep 01, high-impedance 10 and play 11.
// - The power state and mute register at offset 3h resets to 0x10.
// - The output stage register at offset 2h resets to 0x00.
`ifndef AMP_CTRL_CONSTS_VH
`define AMP_CTRL_CONSTS_VH
`define OFS_SOFT_RESET 8'h01
`define OFS_OUTPUT_STAGE 8'h02
`define OFS_POWER_STATE 8'h03
`define BIT_CORE_RESET 4
`define BIT_REG_RESET 0
`define RST_OUTPUT_STAGE 8'h00
`define RST_POWER_STATE 8'h10
`define MASK_OUTPUT_STAGE 8'h77
`define MASK_POWER_STATE 8'h1b
`define BIT_PARALLEL 2
`define BIT_DSP_HOLD 4
`define BIT_MUTE 3
`define FSW_384K 3'h0
`define FSW_480K 3'h2
`define FSW_576K 3'h3
`define FSW_768K 3'h4
`define MOD_DUAL 2'h0
`define MOD_SINGLE 2'h1
`define MOD_HYBRID 2'h2
`define ST_DEEP_SLEEP 2'h0
`define ST_SLEEP 2'h1
`define ST_HIZ 2'h2
`define ST_PLAY 2'h3
`define CORE_RESET_CYCLES 8'h10
`define RAMP_STEP_CYCLES 8'h0a
`endif

// file: src/amp_device_control_regs.v
// device control register group of the class-d amplifier
`timescale 1ns/100ps
`default_nettype none
`include "amp_ctrl_consts.vh"
module amp_device_control_regs #(
  parameter [7:0] RAMP_STEP = 8'h0a
) (
  input wire clk_sys,
  input wire rst_n,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg core_soft_reset,
  output reg coef_clear,
  output reg [1:0] fsw_code,
  output reg fsw_reserved,
  output reg parallel_bridge_output,
  output reg [1:0] modulation_scheme,
  output reg dsp_hold,
  output reg [7:0] volume_gain,
  output reg mute_done,
  output reg [1:0] power_state,
  output reg outputs_hiz,
  output reg play_active
);
  // stored state and its next values
  reg [7:0] out_stage_r;
  reg [7:0] out_stage_nxt;
  reg [7:0] pwr_mute_r;
  reg [7:0] pwr_mute_nxt;
  reg [7:0] core_cnt_r;
  reg [7:0] core_cnt_nxt;
  reg [7:0] ramp_cnt_r;
  reg [7:0] ramp_cnt_nxt;
  reg [7:0] gain_r;
  reg [7:0] gain_nxt;

  // write decode; the reset register holds no storage at all
  wire wr_reset = wr_en && (reg_addr == `OFS_SOFT_RESET);
  wire wr_out_stage = wr_en && (reg_addr == `OFS_OUTPUT_STAGE);
  wire wr_pwr_mute = wr_en && (reg_addr == `OFS_POWER_STATE);
  wire core_hit = wr_reset && wr_data[`BIT_CORE_RESET];
  wire reg_hit = wr_reset && wr_data[`BIT_REG_RESET];
  wire core_busy = (core_cnt_r != 8'h00);
  wire regs_to_default = core_hit || core_busy || reg_hit;
  wire [2:0] fsw_f = out_stage_r[6:4];
  wire [1:0] state_f = pwr_mute_r[1:0];
  wire mute_req = pwr_mute_r[`BIT_MUTE];
  wire ramp_tick = (ramp_cnt_r == 8'h00);

  function [1:0] fsw_enc;
    input [2:0] f;
    begin
      case (f)
        `FSW_384K: fsw_enc = 2'h0;
        `FSW_480K: fsw_enc = 2'h1;
        `FSW_576K: fsw_enc = 2'h2;
        `FSW_768K: fsw_enc = 2'h3;
        default: fsw_enc = 2'h0;
      endcase
    end
  endfunction

  // reserved codes fall back to the slowest rate, flagged separately
  function fsw_rsvd;
    input [2:0] f;
    begin
      case (f)
        `FSW_384K: fsw_rsvd = 1'b0;
        `FSW_480K: fsw_rsvd = 1'b0;
        `FSW_576K: fsw_rsvd = 1'b0;
        `FSW_768K: fsw_rsvd = 1'b0;
        default: fsw_rsvd = 1'b1;
      endcase
    end
  endfunction

  // unmapped offsets and the strobe register read as zero
  function [7:0] read_mux;
    input [7:0] a;
    input [7:0] stage;
    input [7:0] pwr;
    begin
      case (a)
        `OFS_SOFT_RESET: read_mux = 8'h00;
        `OFS_OUTPUT_STAGE: read_mux = stage;
        `OFS_POWER_STATE: read_mux = pwr;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // core reset holds defaults for its whole pulse, so writes then are lost
  always @* begin
    out_stage_nxt = out_stage_r;
    if (regs_to_default) begin
      out_stage_nxt = `RST_OUTPUT_STAGE;
    end else if (wr_out_stage) begin
      out_stage_nxt = wr_data & `MASK_OUTPUT_STAGE;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      out_stage_r <= `RST_OUTPUT_STAGE;
    end else begin
      out_stage_r <= out_stage_nxt;
    end
  end

  always @* begin
    pwr_mute_nxt = pwr_mute_r;
    if (regs_to_default) begin
      pwr_mute_nxt = `RST_POWER_STATE;
    end else if (wr_pwr_mute) begin
      pwr_mute_nxt = wr_data & `MASK_POWER_STATE;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pwr_mute_r <= `RST_POWER_STATE;
    end else begin
      pwr_mute_r <= pwr_mute_nxt;
    end
  end

  // a second core write during the pulse restarts it
  always @* begin
    core_cnt_nxt = core_cnt_r;
    if (core_hit) begin
      core_cnt_nxt = `CORE_RESET_CYCLES;
    end else if (core_busy) begin
      core_cnt_nxt = core_cnt_r - 8'h01;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      core_cnt_r <= 8'h00;
    end else begin
      core_cnt_r <= core_cnt_nxt;
    end
  end

  // one gain step every RAMP_STEP+1 cycles; slow enough to avoid pops
  always @* begin
    ramp_cnt_nxt = ramp_cnt_r - 8'h01;
    if (core_busy) begin
      ramp_cnt_nxt = 8'h00;
    end else if (ramp_tick) begin
      ramp_cnt_nxt = RAMP_STEP;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ramp_cnt_r <= 8'h00;
    end else begin
      ramp_cnt_r <= ramp_cnt_nxt;
    end
  end

  always @* begin
    gain_nxt = gain_r;
    if (core_busy) begin
      gain_nxt = 8'hff;
    end else if (ramp_tick && mute_req && (gain_r != 8'h00)) begin
      gain_nxt = gain_r - 8'h01;
    end else if (ramp_tick && !mute_req && (gain_r != 8'hff)) begin
      gain_nxt = gain_r + 8'h01;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      gain_r <= 8'hff;
    end else begin
      gain_r <= gain_nxt;
    end
  end

  // every output below comes straight from its own flip-flop
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= read_mux(reg_addr, out_stage_r, pwr_mute_r);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      core_soft_reset <= 1'b0;
    end else begin
      core_soft_reset <= core_hit || core_busy;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      coef_clear <= 1'b0;
    end else begin
      coef_clear <= core_hit;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fsw_code <= 2'h0;
    end else begin
      fsw_code <= fsw_enc(fsw_f);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fsw_reserved <= 1'b0;
    end else begin
      fsw_reserved <= fsw_rsvd(fsw_f);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      parallel_bridge_output <= 1'b0;
    end else begin
      parallel_bridge_output <= out_stage_r[`BIT_PARALLEL];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      modulation_scheme <= `MOD_DUAL;
    end else begin
      modulation_scheme <= out_stage_r[1:0];
    end
  end

  // the dsp stays held while a core reset runs, whatever the bit says
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dsp_hold <= 1'b1;
    end else begin
      dsp_hold <= pwr_mute_r[`BIT_DSP_HOLD] || core_busy;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      volume_gain <= 8'hff;
    end else begin
      volume_gain <= gain_r;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mute_done <= 1'b0;
    end else begin
      mute_done <= mute_req && (gain_r == 8'h00);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      power_state <= `ST_DEEP_SLEEP;
    end else begin
      power_state <= state_f;
    end
  end

  // every state but play leaves the outputs floating
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      outputs_hiz <= 1'b1;
    end else begin
      outputs_hiz <= (state_f != `ST_PLAY);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      play_active <= 1'b0;
    end else begin
      play_active <= (state_f == `ST_PLAY);
    end
  end
endmodule
`default_nettype wire

// file: verif/amp_host_model.sv
// host model for the register port
`timescale 1ns/100ps
`default_nettype none
module amp_host_model(input wire logic clk_sys, input wire logic [7:0] rd_data,
  output logic wr_en = 1'b0, rd_en = 1'b0, output logic [7:0] reg_addr = 8'h00, wr_data = 8'h00);
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    reg_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// file: verif/amp_regs_chk_sva.sv
// assertions on the control register group ports
`timescale 1ns/100ps
`default_nettype none
module amp_regs_chk(input wire logic clk_sys, rst_n, wr_en, rd_en, core_soft_reset, coef_clear,
  dsp_hold, play_active, rd_valid, input wire logic [7:0] reg_addr, wr_data, rd_data);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // writes landing inside a core reset are dropped, so they prove nothing
  wire w1 = wr_en && reg_addr == 8'h01 && !core_soft_reset;
  wire w3 = wr_en && reg_addr == 8'h03 && !core_soft_reset;
  core_rst_a:
    assert property (w1 && wr_data[4] |=> core_soft_reset && coef_clear) else $error("core");
  core_len_a:
    assert property ($rose(core_soft_reset) |-> ##16 core_soft_reset ##1 !core_soft_reset)
    else $error("core length");
  reg_rst_a:
    assert property (w1 && wr_data == 8'h01 |=> !coef_clear ##1 dsp_hold) else $error("reg");
  strobe_read_a:
    assert property (rd_en && reg_addr == 8'h01 |=> rd_data == 8'h00) else $error("strobe");
  dsp_run_a: assert property (w3 && !wr_data[4] |-> ##2 !dsp_hold) else $error("dsp");
  play_on_a:
    assert property (w3 && wr_data[1:0] == 2'h3 |-> ##2 play_active) else $error("play");
  hold_out_a: assert property ($rose(rst_n) |-> dsp_hold) else $error("hold");
  rd_pulse_a: assert property (rd_valid == $past(rd_en)) else $error("read valid");
  rsvd_read_a:
    assert property (rd_en && reg_addr == 8'h02 |=> !rd_data[7] && !rd_data[3]) else $error("rsvd");
endmodule
bind amp_device_control_regs amp_regs_chk amp_regs_chk_inst(.*);
`default_nettype wire

// file: verif/test_amp_device_control_regs.sv
// self-checking bench for the control register group
`timescale 1ns/100ps
`default_nettype none
module test_amp_device_control_regs;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en, rd_en, rd_valid, core_soft_reset, coef_clear, fsw_reserved, parallel_bridge_output;
  logic dsp_hold, mute_done, outputs_hiz, play_active;
  logic [7:0] reg_addr, wr_data, rd_data, volume_gain, v, d;
  logic [1:0] fsw_code, modulation_scheme, power_state;
  int failures = 0;
  int samples_checked = 0;
  initial forever #50 clk_sys = ~clk_sys;
  amp_host_model amp_host_model_inst(.*);
  // two cycles per gain step keeps the ramps short
  amp_device_control_regs #(.RAMP_STEP(8'h01)) amp_device_control_regs_inst(.*);
  task chk(input string n, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task w(input logic [7:0] a, x);
    amp_host_model_inst.wr(a, x);
  endtask
  task r(input logic [7:0] a, e);
    amp_host_model_inst.rd(a, v);
    chk("readback", e, v);
  endtask
  task finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    r(8'h01, 8'h00);
    r(8'h02, 8'h00);
    r(8'h03, 8'h10);
    for (int i = 0; i < 4; i++) begin
      d = {1'b1, i == 0 ? 3'h0 : 3'(i + 1), 1'b1, i[0], 2'(i % 3)};
      w(8'h02, d);
      r(8'h02, d & 8'h77);
      chk("fsw", 8'(i), 8'(fsw_code));
      chk("bridge", 8'(i[0]), 8'(parallel_bridge_output));
      chk("mod", 8'(i % 3), 8'(modulation_scheme));
    end
    w(8'h02, 8'h50);
    r(8'h02, 8'h50);
    chk("fsw_rsvd", 8'h01, 8'(fsw_reserved));
    chk("fsw_fallback", 8'h00, 8'(fsw_code));
    for (int s = 0; s < 4; s++) begin
      w(8'h03, 8'(s));
      r(8'h03, 8'(s));
      chk("play", 8'(s == 3), 8'(play_active));
      chk("state", 8'(s), 8'(power_state));
      chk("hiz", 8'(s != 3), 8'(outputs_hiz));
    end
    chk("dsp", 8'h00, 8'(dsp_hold));
    w(8'h03, 8'h0b);
    for (int k = 0; k < 600 && mute_done !== 1'b1; k++) @(posedge clk_sys);
    chk("gain_down", 8'h00, volume_gain);
    w(8'h03, 8'h03);
    for (int k = 0; k < 600 && volume_gain !== 8'hff; k++) @(posedge clk_sys);
    chk("gain_up", 8'hff, volume_gain);
    w(8'h02, 8'h21);
    w(8'h01, 8'h01);
    r(8'h03, 8'h10);
    r(8'h02, 8'h00);
    w(8'h02, 8'h21);
    w(8'h01, 8'h10);
    repeat (20) @(posedge clk_sys);
    r(8'h02, 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
